// ==== rtl/adc_parallel_result_port.sv ====
/*
 Parallel host port of a 16-bit sampling converter: conversion start,
 active-low busy, byte or word readout on three-state data pins.
 Assumes conversion words arrive from the converter core on the same clock;
 host pins are asynchronous and are synchronised here.
*/
// Operation
// [R1] Busy low from start until result updated
// [R2] Byte select low upper, high lower
// [R3] Chip-select falling with read/convert low starts
// [R4] Data pins released unless selected and reading
// [R5] Pin 15 carries result most significant bit
// [R6] Result is two's complement, sixteen bits
// [R7] Read/convert falling starts; rising enables output
// [R8] Pin 0 carries result least significant bit
// [R9] Busy high when idle, including after reset
`timescale 1ns/100ps
module adc_parallel_result_port
   import adc_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic chipSel_b,
   input wire logic readConv,
   input wire logic byteSel,
   input wire logic [15:0] sampleIn,
   input wire logic sampleValid,
   output logic sampleReady,
   output logic convStart,
   output logic busy_b,
   output logic [15:0] dataOut,
   output logic [15:0] dataOe_b
);
   logic [1:0] csSync_reg, rcSync_reg, byteSync_reg;
   logic csPrev_reg, rcPrev_reg;
   logic cs_b, rc, byteHi, startReq, readOn;
   conv_state_t state_reg, state_next;
   logic [5:0] count_reg, count_next;
   logic [15:0] result_reg, result_next;
   logic busy_b_reg, busy_b_next, start_reg, start_next;
   logic [15:0] dout_reg, dout_next, oe_reg, oe_next;
   logic [3:0] level_reg, level_next;
   logic ready_reg, ready_next, pushOk, popOk;

   stream_if #(.WIDTH(RESULT_WIDTH)) fifoIn ();
   stream_if #(.WIDTH(RESULT_WIDTH)) fifoOut ();

   // Core words are buffered so a slow read stalls the converter core only when FIFO_DEPTH words are waiting
   // Ready comes from a local fill count so the core sees a flop, not FIFO logic
   assign fifoIn.valid = sampleValid && ready_reg;
   assign fifoIn.data = sampleIn;
   assign pushOk = sampleValid && ready_reg;
   assign popOk = fifoOut.valid && fifoOut.ready;

   always_comb begin
      level_next = level_reg;
      if (pushOk && !popOk) begin
         level_next = level_reg + 4'h1;
      end else if (popOk && !pushOk) begin
         level_next = level_reg - 4'h1;
      end
      ready_next = level_next != 4'(FIFO_DEPTH);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_reg <= 4'h0;
         ready_reg <= 1'b1;
      end else begin
         level_reg <= level_next;
         ready_reg <= ready_next;
      end
   end

   result_fifo #(.WIDTH(RESULT_WIDTH), .DEPTH(FIFO_DEPTH)) fifoInst (
      .clk(clk),
      .rst_b(rst_b),
      .inS(fifoIn),
      .outS(fifoOut)
   );

   assign cs_b = csSync_reg[1];
   assign rc = rcSync_reg[1];
   assign byteHi = byteSync_reg[1];
   // Internally ORed low-active start: the later falling input triggers
   assign startReq = !cs_b && !rc && (csPrev_reg || rcPrev_reg); // [R3] [R7]
   assign readOn = !cs_b && rc; // [R4] [R7]
   // Words are taken only at a conversion's end; a restart in that cycle must not lose one
   assign fifoOut.ready = (state_reg == S_CONV) && (count_reg == 6'h00) && !startReq;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      result_next = result_reg;
      busy_b_next = busy_b_reg;
      start_next = 1'b0;
      unique case (state_reg)
         S_IDLE: begin
            busy_b_next = 1'b1; // [R9]
            if (startReq) begin
               state_next = S_CONV;
               count_next = CONV_COUNT_W6 - 6'h01;
               busy_b_next = 1'b0; // [R1]
               start_next = 1'b1;
            end
         end
         S_CONV: begin
            busy_b_next = 1'b0; // [R1]
            if (startReq) begin
               // A new command aborts the conversion and restarts it
               count_next = CONV_COUNT_W6 - 6'h01;
               start_next = 1'b1;
            end else if (count_reg != 6'h00) begin
               count_next = count_reg - 6'h01;
            end else if (fifoOut.valid) begin
               result_next = fifoOut.data; // [R6]
               busy_b_next = 1'b1; // [R1]
               state_next = S_IDLE;
            end
         end
      endcase
   end

   always_comb begin
      oe_next = readOn ? 16'h0000 : 16'hffff; // [R4]
      // Bit 15 and bit 0 stay at their result weights in word form
      dout_next = result_reg; // [R5] [R8]
      if (readOn && byteHi) begin
         dout_next = {8'h00, result_reg[HALF_WIDTH-1:0]}; // [R2]
      end else if (readOn) begin
         dout_next = {result_reg[RESULT_WIDTH-1:HALF_WIDTH], result_reg[HALF_WIDTH-1:0]}; // [R2]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         csSync_reg <= 2'h3;
         rcSync_reg <= 2'h3;
         byteSync_reg <= 2'h0;
         csPrev_reg <= 1'b1;
         rcPrev_reg <= 1'b1;
         state_reg <= S_IDLE;
         count_reg <= 6'h00;
         result_reg <= RESULT_RESET;
         busy_b_reg <= 1'b1;
         start_reg <= 1'b0;
         dout_reg <= 16'h0000;
         oe_reg <= 16'hffff;
      end else begin
         csSync_reg <= {csSync_reg[0], chipSel_b};
         rcSync_reg <= {rcSync_reg[0], readConv};
         byteSync_reg <= {byteSync_reg[0], byteSel};
         csPrev_reg <= cs_b;
         rcPrev_reg <= rc;
         state_reg <= state_next;
         count_reg <= count_next;
         result_reg <= result_next;
         busy_b_reg <= busy_b_next;
         start_reg <= start_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
      end
   end

   assign sampleReady = ready_reg;
   assign busy_b = busy_b_reg;
   assign convStart = start_reg;
   assign dataOut = dout_reg;
   assign dataOe_b = oe_reg;

   a_busy_on_start: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      startReq |-> ##1 !busy_b ##1 !busy_b)
      else $error("Busy not low after start");
   a_busy_idle: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
      (state_reg == S_IDLE && !startReq) |-> ##1 busy_b)
      else $error("Busy low while idle");
   a_busy_rise_loads: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      $rose(busy_b) |-> result_reg == $past(fifoOut.data))
      else $error("Busy rose without new result");
   a_start_condition: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
      (!cs_b && !rc && $past(cs_b) && !$past(rc)) |-> ##1 convStart)
      else $error("Chip-select fall did not start");
   a_start_rc_fall: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
      (!cs_b && !rc && $past(rc) && !$past(cs_b)) |-> ##1 convStart)
      else $error("Read/convert fall did not start");
   a_release_pins: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
      (cs_b || !rc) |-> ##1 (dataOe_b == 16'hffff))
      else $error("Pins driven outside read");
   a_drive_pins: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
      (!cs_b && rc) |-> ##1 (dataOe_b == 16'h0000))
      else $error("Pins not driven in read");
   a_upper_byte: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
      (readOn && !byteHi) |-> ##1 (dataOut[15:8] == $past(result_reg[15:8])))
      else $error("Upper byte wrong");
   a_lower_byte: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
      (readOn && byteHi) |-> ##1 (dataOut[7:0] == $past(result_reg[7:0])))
      else $error("Lower byte wrong");
   a_msb_lsb: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R8]
      (readOn && !byteHi) |-> ##1 (dataOut[15] == $past(result_reg[15])
         && dataOut[0] == $past(result_reg[0])))
      else $error("Bit order wrong");
   a_ready_matches_fifo: assert property (@(posedge clk) disable iff (!rst_b)
      sampleReady == fifoIn.ready)
      else $error("Ready disagrees with FIFO fill");
   a_pop_ends_busy: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      (fifoOut.valid && fifoOut.ready) |-> ##1 busy_b)
      else $error("Word taken without ending busy");
   a_busy_full_time: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      startReq |-> ##40 !busy_b)
      else $error("Busy ended before conversion time");
   a_start_busy_low: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      convStart |-> !busy_b)
      else $error("Start pulse without busy");
   a_start_single: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
      convStart |-> ##1 !convStart)
      else $error("Start pulse longer than one cycle");
   a_word_whole: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
      (readOn && !byteHi) |-> ##1 (dataOut == $past(result_reg)))
      else $error("Word read differs from result");
   a_upper_zero_low: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
      (readOn && byteHi) |-> ##1 (dataOut[15:8] == 8'h00))
      else $error("Upper pins not cleared in byte read");
   a_result_steady: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      (state_reg == S_IDLE) |-> ##1 (result_reg == $past(result_reg)))
      else $error("Result changed while idle");
endmodule

// ==== rtl/adc_port_pkg.sv ====
/*
 Shared constants for the parallel result port of the sampling converter.
 Assumes a single 25 MHz clock domain.
*/
package adc_port_pkg;
   localparam int RESULT_WIDTH = 16;
   localparam int HALF_WIDTH = 8;
   localparam int RESULT_MSB_POS = 15;
   localparam int RESULT_LSB_POS = 0;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS = 1600;
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [5:0] CONV_COUNT_W6 = 6'(CONV_CYCLES);
   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_CONV = 2'b10
   } conv_state_t;
endpackage

// ==== rtl/stream_if.sv ====
/*
 Valid/ready word carrier between the port and its result FIFO.
 Assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// ==== rtl/result_fifo.sv ====
/*
 Synchronous FIFO with parameters for width and depth.
 Assumes one clock; depth is a power of two.
*/
`timescale 1ns/100ps
module result_fifo #(parameter int WIDTH = 16, parameter int DEPTH = 8) (
   input wire logic clk,
   input wire logic rst_b,
   stream_if.sink inS,
   stream_if.source outS
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic push, pop, full, empty;

   assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
   assign empty = wrPtr_reg == rdPtr_reg;
   assign inS.ready = !full;
   assign outS.valid = !empty;
   assign outS.data = mem[rdPtr_reg[AW-1:0]];
   assign push = inS.valid && !full;
   assign pop = outS.ready && !empty;

   always_comb begin
      wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg[AW-1:0]] <= inS.data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
      end
   end

   a_no_overflow: assert property (@(posedge clk) disable iff (!rst_b)
      full |-> ##1 (wrPtr_reg == $past(wrPtr_reg)))
      else $error("FIFO written while full");
endmodule

// ==== tb/host_model.sv ====
/*
 Host logic model: starts conversions and reads words or bytes.
 Assumes the port samples its pins on clk; drives on falling edges.
*/
`timescale 1ns/100ps
module host_model (
   input wire logic clk,
   output logic chipSel_b,
   output logic readConv,
   output logic byteSel
);
   initial begin
      chipSel_b = 1'b1;
      readConv = 1'b1;
      byteSel = 1'b0;
   end
   task automatic wt(int n);
      repeat (n) @(negedge clk);
   endtask
   // Second pin falls two cycles late so it alone makes the start
   task automatic start(bit useCs);
      wt(1);
      if (useCs) begin
         readConv = 1'b0;
         wt(2);
         chipSel_b = 1'b0;
      end else begin
         chipSel_b = 1'b0;
         wt(2);
         readConv = 1'b0;
      end
      wt(3);
      chipSel_b = 1'b1;
      readConv = 1'b1;
   endtask
   task automatic read(bit half);
      wt(1);
      byteSel = half;
      chipSel_b = 1'b0;
      wt(5);
   endtask
   task automatic idle();
      wt(1);
      chipSel_b = 1'b1;
      wt(5);
   endtask
endmodule

// ==== tb/adc_parallel_result_port_tb.sv ====
/*
 Self-checking bench for the parallel result port.
 Assumes the host model on the pins; the bench feeds the core stream.
*/
`timescale 1ns/100ps
module adc_parallel_result_port_tb;
   import adc_port_pkg::*;
   logic clk = 0, rst_b = 0, sampleValid = 0;
   logic sampleReady, convStart, busy_b, chipSel_b, readConv, byteSel;
   logic [15:0] sampleIn = 0, dataOut, dataOe_b, w;
   logic [15:0] corner[4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
   logic [31:0] seed = 32'h5a0a80d7;
   int error_cnt = 0, compares = 0, starts = 0, n;
   logic [15:0] q[$];
   always #20 clk = ~clk;
   always @(posedge clk) if (convStart === 1'b1) starts <= starts + 1;
   host_model u_host_model (.clk(clk), .chipSel_b(chipSel_b), .readConv(readConv),
      .byteSel(byteSel));
   adc_parallel_result_port u_adc_parallel_result_port (.clk(clk), .rst_b(rst_b),
      .chipSel_b(chipSel_b), .readConv(readConv), .byteSel(byteSel), .sampleIn(sampleIn),
      .sampleValid(sampleValid), .sampleReady(sampleReady), .convStart(convStart),
      .busy_b(busy_b), .dataOut(dataOut), .dataOe_b(dataOe_b));
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic push(logic [15:0] d, bit keep);
      @(negedge clk);
      sampleIn = d;
      sampleValid = 1'b1;
      if (keep) q.push_back(d);
      @(negedge clk);
      sampleValid = 1'b0;
   endtask
   task automatic conv(bit useCs);
      int s0;
      s0 = starts;
      u_host_model.start(useCs);
      @(negedge clk);
      chk("busy_b", {15'h0, busy_b}, 16'h0);
      chk("starts", 16'(starts - s0), 16'h1);
   endtask
   task automatic waitIdle();
      n = 0;
      while (busy_b !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic readBack();
      w = q.pop_front();
      u_host_model.read(1'b0);
      chk("word", dataOut, w);
      chk("oe read", dataOe_b, 16'h0000);
      u_host_model.read(1'b1);
      chk("low byte", dataOut, {8'h00, w[7:0]});
      u_host_model.idle();
      chk("oe idle", dataOe_b, 16'hffff);
      $display("Test word %h done", w);
   endtask
   initial begin
      #200000;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (2) @(negedge clk);
      chk("reset busy", {15'h0, busy_b}, 16'h1);
      chk("reset oe", dataOe_b, 16'hffff);
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      // Fill the FIFO with corner values then random ones, then overfill
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         seed = xs(seed);
         push(i < 4 ? corner[i] : seed[15:0], 1'b1);
      end
      chk("full", {15'h0, sampleReady}, 16'h0);
      push(16'h5555, 1'b0);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         conv(i[0]);
         waitIdle();
         readBack();
      end
      chk("drained", {15'h0, sampleReady}, 16'h1);
      $display("Test fill and drain done");
      // Restart mid-conversion stretches busy past the first count
      seed = xs(seed);
      push(seed[15:0], 1'b1);
      conv(1'b0);
      repeat (20) @(negedge clk);
      conv(1'b1);
      waitIdle();
      chk("restart", 16'(n > 30), 16'h1);
      readBack();
      $display("Test restart done");
      // No word yet: busy must hold until the result exists
      conv(1'b0);
      repeat (60) @(negedge clk);
      chk("no word busy", {15'h0, busy_b}, 16'h0);
      push(16'h8001, 1'b1);
      waitIdle();
      readBack();
      $display("Test late word done");
      stop_test();
   end
endmodule
